// *** rtl/serial_rx.sv ***
// Receive half of an asynchronous serial interface with 16x oversampling
`timescale 1ns/1ps
`default_nettype none
module serial_rx
    import serial_rx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic receive_data_pin_i,
    input wire logic receiver_enable_i,
    input wire logic nine_bit_mode_i,
    input wire logic receive_interrupt_enable_i,
    input wire logic [DIV_WIDTH-1:0] tick_divisor_i,
    input wire logic buffer_read_i,
    output logic [7:0] serial_data_buffer_o,
    output logic received_bit_eight_o,
    output rx_status_type rx_status_o,
    output logic rx_irq_o
);
    // ------------------------------------------------------------------
    // Pin synchroniser and oversample tick
    // ------------------------------------------------------------------
    logic pin_meta_q;
    logic pin_q;
    logic oversample_tick;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta_q <= 1'b1;
            pin_q <= 1'b1;
        end else begin
            pin_meta_q <= receive_data_pin_i;
            pin_q <= pin_meta_q;
        end
    end

    oversample_tick_gen tick_gen (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_divisor_i(tick_divisor_i),
        .oversample_tick_o(oversample_tick)
    );

    // ------------------------------------------------------------------
    // Receiver state
    // ------------------------------------------------------------------
    rx_state_type state_q;
    rx_state_type state_d;
    logic [4:0] tick_cnt_q;
    logic [4:0] tick_cnt_d;
    logic [3:0] bit_idx_q;
    logic [3:0] bit_idx_d;
    logic [2:0] hist_q;
    logic [2:0] hist_d;
    logic [1:0] ones_q;
    logic [1:0] ones_d;
    logic [8:0] shift_q;
    logic [8:0] shift_d;
    logic noise_acc_q;
    logic noise_acc_d;
    logic armed_q;
    logic armed_d;
    logic char_done;

    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic disagree3(input logic [2:0] s);
        disagree3 = (s != 3'b000) && (s != 3'b111);
    endfunction

    // ------------------------------------------------------------------
    // Sample decoding
    // ------------------------------------------------------------------
    logic [2:0] triple;
    logic bit_value;
    logic bit_noise;
    logic [1:0] start_ones;
    logic start_seen;
    logic fall_edge;
    logic resync_early;
    logic resync_late;
    logic cnt_wrap;
    logic [3:0] last_bit;
    logic at_tick10;
    logic start_reject;
    logic start_noise;
    logic [4:0] tick_next;

    assign triple = {hist_q[1:0], pin_q};
    assign bit_value = majority3(triple);
    assign bit_noise = disagree3(triple);
    assign start_ones = ones_q + {1'b0, pin_q};
    assign start_reject = (start_ones >= 2'b10);
    assign start_noise = (start_ones == 2'b01);
    assign start_seen = (hist_q == 3'b111) && !pin_q;
    assign fall_edge = hist_q[0] && !pin_q;
    assign at_tick10 = (tick_cnt_q == TICK_10);
    // The edge sample counts as tick 16 of the bit before it, so the
    // sample after any realignment is tick 1
    assign tick_next = (tick_cnt_q == TICK_16) ? TICK_1 : tick_cnt_q + 5'h01;
    // Only a 1-to-0 change is a safe edge; a 0 bit followed by 0 has none
    assign resync_late = armed_q && fall_edge &&
                         (tick_cnt_q > TICK_10);
    assign resync_early = armed_q && fall_edge &&
                          (tick_cnt_q < TICK_8);
    assign cnt_wrap = (tick_cnt_q == TICK_16) || resync_late;
    assign last_bit = nine_bit_mode_i ? LAST_BIT_NINE : LAST_BIT_EIGHT;

    always_comb begin
        state_d = state_q;
        tick_cnt_d = tick_cnt_q;
        bit_idx_d = bit_idx_q;
        hist_d = hist_q;
        ones_d = ones_q;
        shift_d = shift_q;
        noise_acc_d = noise_acc_q;
        armed_d = armed_q;
        char_done = 1'b0;
        if (!receiver_enable_i) begin
            state_d = ST_SEARCH;
            hist_d = 3'b000;
        end else if (oversample_tick) begin
            hist_d = {hist_q[1:0], pin_q};
            tick_cnt_d = tick_next;
            case (state_q)
                ST_SEARCH: begin
                    if (start_seen) begin
                        state_d = ST_START;
                        tick_cnt_d = TICK_1;
                        ones_d = 2'b00;
                        noise_acc_d = 1'b0;
                        armed_d = 1'b0;
                    end
                end
                ST_START: begin
                    if (tick_cnt_q == TICK_3 || tick_cnt_q == TICK_5) begin
                        ones_d = start_ones;
                    end
                    if (tick_cnt_q == TICK_7) begin
                        if (start_reject) begin
                            state_d = ST_SEARCH;
                            hist_d = 3'b000;
                            tick_cnt_d = TICK_1;
                        end else if (start_noise) begin
                            noise_acc_d = 1'b1;
                        end
                    end
                    if (at_tick10 && (triple != 3'b000)) begin
                        noise_acc_d = 1'b1;
                    end
                    if (tick_cnt_q == TICK_16) begin
                        state_d = ST_DATA;
                        bit_idx_d = BIT_FIRST;
                    end
                end
                ST_DATA: begin
                    if (at_tick10) begin
                        shift_d = {bit_value, shift_q[8:1]};
                        noise_acc_d = noise_acc_q | bit_noise;
                        armed_d = bit_value;
                    end
                    if (resync_early) begin
                        tick_cnt_d = TICK_1;
                        armed_d = 1'b0;
                    end else if (cnt_wrap) begin
                        tick_cnt_d = TICK_1;
                        armed_d = armed_q && !resync_late;
                        if (bit_idx_q == last_bit) begin
                            state_d = ST_STOP;
                        end else begin
                            bit_idx_d = bit_idx_q + 4'h1;
                        end
                    end
                end
                ST_STOP: begin
                    if (resync_early) begin
                        tick_cnt_d = TICK_1;
                        armed_d = 1'b0;
                    end else if (at_tick10) begin
                        char_done = 1'b1;
                        state_d = ST_SEARCH;
                        hist_d = 3'b000;
                    end
                end
                default: begin
                    state_d = ST_SEARCH;
                    hist_d = 3'b000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_SEARCH;
            tick_cnt_q <= TICK_1;
            bit_idx_q <= BIT_FIRST;
            hist_q <= 3'b000;
            ones_q <= 2'b00;
            shift_q <= 9'h000;
            noise_acc_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tick_cnt_q <= tick_cnt_d;
            bit_idx_q <= bit_idx_d;
            hist_q <= hist_d;
            ones_q <= ones_d;
            shift_q <= shift_d;
            noise_acc_q <= noise_acc_d;
            armed_q <= armed_d;
        end
    end

    // ------------------------------------------------------------------
    // Character completion and status flags
    // ------------------------------------------------------------------
    logic [7:0] char_data;
    logic char_bit_eight;
    logic stop_error;
    logic char_break;
    logic accept;
    logic [7:0] buffer_q;
    logic [7:0] buffer_d;
    logic bit_eight_q;
    logic bit_eight_d;
    rx_status_type status_q;
    rx_status_type status_d;

    // In eight-bit mode the top of the shifter already holds bit seven
    assign char_data = nine_bit_mode_i ? shift_q[7:0] : shift_q[8:1];
    assign char_bit_eight = shift_q[8];
    assign stop_error = !bit_value;
    // Bit 0 of the shifter is stale in eight-bit mode, so test the fields
    assign char_break = stop_error && (char_data == 8'h00) &&
                        !char_bit_eight;
    // A read in the same cycle frees the buffer for the new character
    assign accept = char_done && (!status_q.receiver_full_flag ||
                                  buffer_read_i);
    assign buffer_d = char_break ? 8'h00 : char_data;
    assign bit_eight_d = char_break ? 1'b0 : char_bit_eight;

    // Hardware set wins over a read that clears in the same cycle
    always_comb begin
        status_d.receiver_full_flag = accept ||
            (status_q.receiver_full_flag && !buffer_read_i);
        status_d.overrun_flag = (char_done && !accept) ||
            (status_q.overrun_flag && !buffer_read_i);
        if (accept) begin
            status_d.noise_flag = noise_acc_q || bit_noise;
            status_d.framing_error_flag = stop_error;
            status_d.break_flag = char_break;
        end else begin
            status_d.noise_flag = status_q.noise_flag && !buffer_read_i;
            status_d.framing_error_flag =
                status_q.framing_error_flag && !buffer_read_i;
            status_d.break_flag = status_q.break_flag && !buffer_read_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            buffer_q <= 8'h00;
            bit_eight_q <= 1'b0;
            status_q <= STATUS_RESET;
        end else begin
            if (accept) begin
                buffer_q <= buffer_d;
                bit_eight_q <= bit_eight_d;
            end
            status_q <= status_d;
        end
    end

    assign serial_data_buffer_o = buffer_q;
    assign received_bit_eight_o = bit_eight_q;
    assign rx_status_o = status_q;
    assign rx_irq_o = status_q.receiver_full_flag &&
                      receive_interrupt_enable_i;
endmodule
`default_nettype wire

// *** rtl/serial_rx_pkg.sv ***
// Shared constants and types of the asynchronous serial receiver
package serial_rx_pkg;

    // ------------------------------------------------------------------
    // Oversample tick positions within one bit time
    // ------------------------------------------------------------------
    localparam logic [4:0] TICK_1 = 5'h01;
    localparam logic [4:0] TICK_3 = 5'h03;
    localparam logic [4:0] TICK_5 = 5'h05;
    localparam logic [4:0] TICK_7 = 5'h07;
    localparam logic [4:0] TICK_8 = 5'h08;
    localparam logic [4:0] TICK_10 = 5'h0a;
    localparam logic [4:0] TICK_16 = 5'h10;

    // ------------------------------------------------------------------
    // Character geometry and tick divider constants
    // ------------------------------------------------------------------
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [3:0] LAST_BIT_NINE = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam int DIV_WIDTH = 16;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Receiver states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_SEARCH = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } rx_state_type;

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    typedef struct packed {
        logic overrun_flag;
        logic break_flag;
        logic framing_error_flag;
        logic noise_flag;
        logic receiver_full_flag;
    } rx_status_type;

    localparam rx_status_type STATUS_RESET = 5'h00;

endpackage

// *** rtl/oversample_tick_gen.sv ***
// Divider that makes the oversample tick enable from the module clock
`timescale 1ns/1ps
`default_nettype none
module oversample_tick_gen
    import serial_rx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [DIV_WIDTH-1:0] tick_divisor_i,
    output logic oversample_tick_o
);
    logic [DIV_WIDTH-1:0] count_q;
    logic [DIV_WIDTH-1:0] count_d;
    logic wrap;

    // Divisor is clock cycles per tick minus one; zero ticks every cycle
    assign wrap = (count_q >= tick_divisor_i);
    assign count_d = wrap ? DIV_RESET : count_q + 1'b1;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_q <= DIV_RESET;
            oversample_tick_o <= 1'b0;
        end else begin
            count_q <= count_d;
            oversample_tick_o <= wrap;
        end
    end
endmodule
`default_nettype wire

// *** tb/serial_rx_monitor.sv ***
// Port-level assertions for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_monitor
    import serial_rx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic receiver_enable_i,
    input wire logic nine_bit_mode_i,
    input wire logic receive_interrupt_enable_i,
    input wire logic buffer_read_i,
    input wire logic [7:0] serial_data_buffer_o,
    input wire logic received_bit_eight_o,
    input wire rx_status_type rx_status_o,
    input wire logic rx_irq_o
);
    // ------------------------------------------------------------------
    // Flag and buffer relations
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_irq;
        rx_irq_o == (rx_status_o.receiver_full_flag
            && receive_interrupt_enable_i);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    // Full may already stand when a read meets a completion
    property p_frame;
        $rose(rx_status_o.framing_error_flag)
            |-> rx_status_o.receiver_full_flag;
    endproperty
    a_frame: assert property (p_frame) else $error("framing without full");
    property p_noise;
        $rose(rx_status_o.noise_flag) |-> rx_status_o.receiver_full_flag;
    endproperty
    a_noise: assert property (p_noise) else $error("noise without full");
    property p_brk;
        $rose(rx_status_o.break_flag) |-> rx_status_o.framing_error_flag
            && serial_data_buffer_o == 8'h00 && !received_bit_eight_o;
    endproperty
    a_brk: assert property (p_brk) else $error("break effects");
    property p_ovr;
        $rose(rx_status_o.overrun_flag)
            |-> $past(rx_status_o.receiver_full_flag)
            && $stable(serial_data_buffer_o) && $stable(received_bit_eight_o);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun kept no data");
    property p_buf;
        $changed(serial_data_buffer_o)
            |-> $rose(rx_status_o.receiver_full_flag) || $past(buffer_read_i);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer moved alone");
    property p_b8;
        $rose(rx_status_o.receiver_full_flag) && !nine_bit_mode_i
            |-> received_bit_eight_o == serial_data_buffer_o[7];
    endproperty
    a_b8: assert property (p_b8) else $error("bit eight not bit seven");
    property p_en;
        $rose(rx_status_o.receiver_full_flag) |-> $past(receiver_enable_i);
    endproperty
    a_en: assert property (p_en) else $error("full while disabled");
endmodule
bind serial_rx serial_rx_monitor i_serial_rx_monitor (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .receiver_enable_i(receiver_enable_i), .nine_bit_mode_i(nine_bit_mode_i),
    .receive_interrupt_enable_i(receive_interrupt_enable_i),
    .buffer_read_i(buffer_read_i), .serial_data_buffer_o(serial_data_buffer_o),
    .received_bit_eight_o(received_bit_eight_o), .rx_status_o(rx_status_o),
    .rx_irq_o(rx_irq_o)
);
`default_nettype wire

// *** tb/serial_tx_model.sv ***
// Behavioural remote transmitter on the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
    input wire logic clk_i,
    output logic line_o
);
    // ------------------------------------------------------------------
    // Frames with bit length in clocks and an optional inverted span
    // ------------------------------------------------------------------
    initial line_o = 1'b1;
    task automatic send(input logic [8:0] data, input int nbits,
        input logic stop, input int bc, input int ga, input int gl);
        int b;
        logic v;
        for (int c = 0; c < (nbits + 2) * bc; c++) begin
            @(posedge clk_i);
            #1;
            b = c / bc;
            v = (b == 0) ? 1'b0 : (b > nbits) ? stop : data[b-1];
            line_o = (c >= ga && c < ga + gl) ? ~v : v;
        end
        @(posedge clk_i);
        #1;
        line_o = 1'b1;
        repeat (2 * bc) @(posedge clk_i);
        #1;
    endtask
    // Short low pulse, then long idle so a new search can find three 1s
    task automatic dip(input int clks);
        @(posedge clk_i);
        #1;
        line_o = 1'b0;
        repeat (clks) @(posedge clk_i);
        #1;
        line_o = 1'b1;
        repeat (40) @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// *** tb/serial_rx_tb.sv ***
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_tb
    import serial_rx_pkg::*;
;
    typedef struct {
        logic [8:0] d; int nb; logic stop; int bc; int ga; int gl;
        logic [8:0] ed; logic [4:0] es;
    } row_type;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic en = 1'b1;
    logic nine = 1'b0;
    logic ie = 1'b1;
    logic rd = 1'b0;
    logic [15:0] div = 16'h0001;
    wire logic pin;
    wire logic [7:0] data;
    wire logic b8;
    wire logic irq;
    rx_status_type st;
    int fails = 0;
    int num_checks = 0;
    // Tick every two clocks, so one bit is 32 clocks
    row_type tbl [11] = '{
        '{9'h0a5, 8, 1'b1, 32, 0, 0, 9'h1a5, 5'h01},
        '{9'h15a, 9, 1'b1, 32, 0, 0, 9'h15a, 5'h01},
        '{9'h05a, 9, 1'b1, 32, 0, 0, 9'h05a, 5'h01},
        '{9'h0c3, 8, 1'b0, 32, 0, 0, 9'h1c3, 5'h05},
        '{9'h000, 8, 1'b0, 32, 0, 0, 9'h000, 5'h0d},
        '{9'h000, 9, 1'b0, 32, 0, 0, 9'h000, 5'h0d},
        '{9'h0a5, 8, 1'b1, 32, 178, 2, 9'h1a5, 5'h03},
        '{9'h0a5, 8, 1'b1, 32, 8, 4, 9'h1a5, 5'h03},
        '{9'h025, 8, 1'b1, 32, 306, 2, 9'h025, 5'h03},
        '{9'h055, 8, 1'b1, 34, 0, 0, 9'h055, 5'h01},
        '{9'h155, 9, 1'b1, 30, 0, 0, 9'h155, 5'h01}
    };
    always #4 clk_i = ~clk_i;
    serial_rx i_serial_rx (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .receive_data_pin_i(pin),
        .receiver_enable_i(en), .nine_bit_mode_i(nine),
        .receive_interrupt_enable_i(ie), .tick_divisor_i(div),
        .buffer_read_i(rd), .serial_data_buffer_o(data),
        .received_bit_eight_o(b8), .rx_status_o(st), .rx_irq_o(irq)
    );
    serial_tx_model i_serial_tx_model (.clk_i(clk_i), .line_o(pin));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [8:0] seen,
        input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic read_buf;
        @(posedge clk_i);
        #1 rd = 1'b1;
        @(posedge clk_i);
        #1 rd = 1'b0;
        check("cleared", {4'h0, st}, 9'h000);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        check("reset data", {b8, data}, 9'h000);
        check("reset status", {4'h0, st}, 9'h000);
        check("reset irq", {8'h00, irq}, 9'h000);
        // The start search needs three idle samples after reset
        repeat (16) @(posedge clk_i);
        foreach (tbl[i]) begin
            nine = (tbl[i].nb == 9);
            i_serial_tx_model.send(tbl[i].d, tbl[i].nb, tbl[i].stop,
                tbl[i].bc, tbl[i].ga, tbl[i].gl);
            check("data", {b8, data}, tbl[i].ed);
            check("status", {4'h0, st}, {4'h0, tbl[i].es});
            check("irq", {8'h00, irq}, 9'h001);
            read_buf();
        end
        nine = 1'b0;
        i_serial_tx_model.dip(4);
        i_serial_tx_model.send(9'h03c, 8, 1'b1, 32, 0, 0);
        check("after reject", {b8, data}, 9'h03c);
        check("after reject status", {4'h0, st}, 9'h001);
        ie = 1'b0;
        i_serial_tx_model.send(9'h0f0, 8, 1'b1, 32, 0, 0);
        check("kept", {b8, data}, 9'h03c);
        check("overrun", {4'h0, st}, 9'h011);
        check("masked", {8'h00, irq}, 9'h000);
        read_buf();
        en = 1'b0;
        i_serial_tx_model.send(9'h081, 8, 1'b1, 32, 0, 0);
        check("disabled", {4'h0, st}, 9'h000);
        en = 1'b1;
        test_done();
    end
    // Run needs about 50 us; four times that marks a hang
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
